// ==== core/event_router_pkg.sv ====
// Shared constants and types for the event router
package event_router_pkg;
  localparam int N_EVENTS  = 105;  // Monitored event inputs
  localparam int N_OUTPUTS = 5;    // Output logic blocks
  localparam int N_IRQ     = 4;    // Outputs routed to the interrupt controller
  localparam int WAKE_IDX  = 4;    // Output routed to the clock_generation_unit
  localparam int WORD_W    = 32;   // Status word width
  localparam int N_WORDS   = 4;    // Status words per 105-bit group
  localparam int FLAT_W    = WORD_W * N_WORDS;  // Padded status width
  localparam int MODE_W    = 2;    // Sensitivity field width per event

  // Per-event sensitivity choice, in field order 0..3
  typedef enum logic [MODE_W-1:0] {
    SENSE_HIGH,
    SENSE_LOW,
    SENSE_RISE,
    SENSE_FALL
  } sense_e;

  localparam logic FLAG_RST = 1'b0;  // Reset value of every flag and status bit
endpackage

// ==== core/ev_link_if.sv ====
// Carrier of raw and pending event vectors between router stages
`timescale 1ns/1ps
`default_nettype none
interface ev_link_if #(
  parameter int N = event_router_pkg::N_EVENTS
);
  logic [N-1:0] raw;      // Output of sensitivity stage
  logic [N-1:0] pending;  // Raw gated by the global mask

  // Detection stage drives, consumers only look
  modport src (output raw, output pending);
  modport dst (input raw, input pending);
endinterface
`default_nettype wire

// ==== core/event_detect.sv ====
// Pin synchroniser, sensitivity selection, edge latch and global mask
`timescale 1ns/1ps
`default_nettype none
module event_detect #(
  parameter int N = event_router_pkg::N_EVENTS
) (
  // Clock and reset
  input  wire logic           sys_clk_in,
  input  wire logic           rst_in,
  // Event sources and configuration
  input  wire logic [N-1:0]   event_in,
  input  wire logic [2*N-1:0] sense_mode_in,
  input  wire logic [N-1:0]   global_mask_in,
  input  wire logic [N-1:0]   edge_clear_in,
  // Results toward the output blocks
  ev_link_if.src              link
);
  logic [N-1:0] sync1_ff;  // First synchroniser stage, read only by sync2_ff
  logic [N-1:0] sync2_ff;  // Second synchroniser stage
  logic [N-1:0] prev_ff;   // Previous synchronised level for edge detect
  logic [N-1:0] edge_ff;   // Sticky edge flags

  localparam int ARM_D = 3;  // Edges until prev_ff holds a real pin sample
  logic [ARM_D-1:0] arm_ff;  // Ones shift in after reset; top bit arms edge detect
  logic [N-1:0] nxt_raw;   // Sensitivity stage result
  logic [N-1:0] raw_ff;    // Registered raw status
  logic [N-1:0] pend_ff;   // Registered pending status

  // Two-stage synchroniser, pins are asynchronous
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
      arm_ff   <= '0;
    end else begin
      sync1_ff <= event_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      arm_ff   <= {arm_ff[ARM_D-2:0], 1'b1};
    end
  end

  // Per-event edge latch and sensitivity mux
  for (genvar i = 0; i < N; i++) begin : g_evt
    event_router_pkg::sense_e mode;  // Decoded mode of this event
    logic                     rise;  // Rising edge seen this cycle
    logic                     fall;  // Falling edge seen this cycle
    assign mode = event_router_pkg::sense_e'(sense_mode_in[2*i +: 2]);
    // Reset zeros in the pipeline would fake an edge on a pin that idles high
    assign rise = arm_ff[ARM_D-1] & sync2_ff[i] & ~prev_ff[i];
    assign fall = arm_ff[ARM_D-1] & ~sync2_ff[i] & prev_ff[i];

    // Set beats clear so a coincident edge is never lost
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        edge_ff[i] <= event_router_pkg::FLAG_RST;
      end else if ((mode == event_router_pkg::SENSE_RISE && rise) ||
                   (mode == event_router_pkg::SENSE_FALL && fall)) begin
        edge_ff[i] <= 1'b1;
      end else if (edge_clear_in[i]) begin
        edge_ff[i] <= 1'b0;
      end
    end

    // Level modes follow the pin, edge modes read the latch
    always_comb begin
      case (mode)
        event_router_pkg::SENSE_HIGH: nxt_raw[i] = sync2_ff[i];
        event_router_pkg::SENSE_LOW:  nxt_raw[i] = ~sync2_ff[i];
        event_router_pkg::SENSE_RISE: nxt_raw[i] = edge_ff[i];
        event_router_pkg::SENSE_FALL: nxt_raw[i] = edge_ff[i];
        default:                      nxt_raw[i] = 1'b0;
      endcase
    end

    // Sticky edge flag holds until cleared
    a_edge_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      edge_ff[i] && !edge_clear_in[i] |=> edge_ff[i])
      else $error("edge flag dropped without clear");

    // Qualified rising edge in rise mode shows on raw two edges later
    a_rise_raw: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      mode == event_router_pkg::SENSE_RISE && rise |=> (mode == event_router_pkg::SENSE_RISE |=> raw_ff[i]))
      else $error("rising edge not seen on raw");
  end

  // Raw and pending stages, one cycle each
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      raw_ff  <= '0;
      pend_ff <= '0;
    end else begin
      raw_ff  <= nxt_raw;
      pend_ff <= raw_ff & global_mask_in;
    end
  end

  assign link.raw     = raw_ff;
  assign link.pending = pend_ff;

  // Pending is exactly the masked raw of the cycle before
  a_pend_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> pend_ff == $past(raw_ff & global_mask_in))
    else $error("pending does not match masked raw");

  // Synchronised level lags the pin by two edges
  a_sync_delay: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && !$past(rst_in, 2) |-> sync2_ff == $past(event_in, 2))
    else $error("synchroniser delay wrong");
endmodule
`default_nettype wire

// ==== core/output_block.sv ====
// One output block: pending AND own mask, OR-reduced
`timescale 1ns/1ps
`default_nettype none
module output_block #(
  parameter int N = event_router_pkg::N_EVENTS
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Pending events and this block's mask
  ev_link_if.dst            link,
  input  wire logic [N-1:0] out_mask_in,
  // Per-event products and block output
  output logic      [N-1:0] product_out,
  output logic              hit_out
);
  logic [N-1:0] prod_ff;  // Masked pending products
  logic         hit_ff;   // OR of all products

  // Products and their OR registered in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prod_ff <= '0;
      hit_ff  <= event_router_pkg::FLAG_RST;
    end else begin
      prod_ff <= link.pending & out_mask_in;
      hit_ff  <= |(link.pending & out_mask_in);
    end
  end

  assign product_out = prod_ff;
  assign hit_out     = hit_ff;

  // Block output equals OR of its visible products
  a_or_reduce: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    hit_ff == (|prod_ff))
    else $error("block output disagrees with products");

  // Products track pending and mask of the previous cycle
  a_prod_map: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> prod_ff == $past(link.pending & out_mask_in))
    else $error("products do not track mask");
endmodule
`default_nettype wire

// ==== core/event_router.sv ====
// Event router top: detection, global mask, five output blocks, status words
`timescale 1ns/1ps
`default_nettype none

module event_router #(
  parameter int N_EVENTS  = event_router_pkg::N_EVENTS,
  parameter int N_OUTPUTS = event_router_pkg::N_OUTPUTS
) (
  // Clock and reset
  input  wire logic                                    sys_clk_in,
  input  wire logic                                    rst_in,
  // Event sources, asynchronous
  input  wire logic [N_EVENTS-1:0]                     event_in,
  // Configuration
  input  wire logic [2*N_EVENTS-1:0]                   sense_mode_in,
  input  wire logic [N_EVENTS-1:0]                     global_mask_in,
  input  wire logic [N_OUTPUTS*N_EVENTS-1:0]           out_mask_in,
  // Edge flag clears, one pulse per event
  input  wire logic [N_EVENTS-1:0]                     edge_clear_in,
  // Status words
  output logic      [event_router_pkg::FLAT_W-1:0]     raw_status_out,
  output logic      [event_router_pkg::FLAT_W-1:0]     pending_out,
  output logic      [N_OUTPUTS*event_router_pkg::FLAT_W-1:0] out_pending_out,
  output logic      [N_OUTPUTS-1:0]                    out_status_out,
  // Routed outputs
  output logic      [event_router_pkg::N_IRQ-1:0]      irq_out,
  output logic                                         wake_out
);
  localparam int FW    = event_router_pkg::FLAT_W;  // Padded status width
  localparam int PAD_W = FW - N_EVENTS;             // Zero bits above the events

  // Refuse sizes that do not fit the status words or routing
  // Padding needs at least one bit, else the zero fill is empty
  if (N_EVENTS < 1 || N_EVENTS >= FW) begin : g_bad_events
    $error("N_EVENTS must lie in 1..FLAT_W-1");
  end
  if (N_OUTPUTS != event_router_pkg::N_OUTPUTS) begin : g_bad_outputs
    $error("N_OUTPUTS must match the routing of irq and wake outputs");
  end

  // Vectors shared by the detection stage and output blocks
  ev_link_if #(.N(N_EVENTS)) link ();

  logic [N_OUTPUTS*N_EVENTS-1:0] product;   // Products of all blocks
  logic [N_OUTPUTS-1:0]          hit;       // Block outputs

  logic [FW-1:0]                 raw_ff;    // Raw status words
  logic [FW-1:0]                 pend_ff;   // Pending status words
  logic [N_OUTPUTS*FW-1:0]       opend_ff;  // Output pending words
  logic [N_OUTPUTS-1:0]          ostat_ff;  // Output status word
  logic [event_router_pkg::N_IRQ-1:0] irq_ff;  // Interrupt lines
  logic                          wake_ff;   // Wake-up line

  // Detection: sync, sensitivity, edge latch, global mask
  event_detect #(
    .N (N_EVENTS)
  ) u_detect (
    .sys_clk_in     (sys_clk_in),
    .rst_in         (rst_in),
    .event_in       (event_in),
    .sense_mode_in  (sense_mode_in),
    .global_mask_in (global_mask_in),
    .edge_clear_in  (edge_clear_in),
    .link           (link.src)
  );

  // Five parallel output blocks, each sees every pending bit
  for (genvar o = 0; o < N_OUTPUTS; o++) begin : g_blk
    output_block #(
      .N (N_EVENTS)
    ) u_blk (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .link        (link.dst),
      .out_mask_in (out_mask_in[o*N_EVENTS +: N_EVENTS]),
      .product_out (product[o*N_EVENTS +: N_EVENTS]),
      .hit_out     (hit[o])
    );
  end

  // Raw and pending words, unused top bits read as zero
  // Zero padding keeps word layout fixed if N_EVENTS shrinks
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      raw_ff  <= '0;
      pend_ff <= '0;
    end else begin
      raw_ff  <= {{PAD_W{1'b0}}, link.raw};
      pend_ff <= {{PAD_W{1'b0}}, link.pending};
    end
  end

  // Output pending words, four words per block
  for (genvar o = 0; o < N_OUTPUTS; o++) begin : g_opend
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        opend_ff[o*FW +: FW] <= '0;
      end else begin
        opend_ff[o*FW +: FW] <= {{PAD_W{1'b0}}, product[o*N_EVENTS +: N_EVENTS]};
      end
    end
  end

  // Output status and routed lines share one sampling edge
  // Keeping them in step lets software trust the status word
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ostat_ff <= '0;
      irq_ff   <= '0;
      wake_ff  <= event_router_pkg::FLAG_RST;
    end else begin
      ostat_ff <= hit;
      irq_ff   <= hit[event_router_pkg::N_IRQ-1:0];
      wake_ff  <= hit[event_router_pkg::WAKE_IDX];
    end
  end

  // Every output straight from a flip-flop
  assign raw_status_out  = raw_ff;
  assign pending_out     = pend_ff;
  assign out_pending_out = opend_ff;
  assign out_status_out  = ostat_ff;
  assign irq_out         = irq_ff;
  assign wake_out        = wake_ff;

  // Raw word mirrors detection result one edge later
  a_raw_words: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> raw_status_out[N_EVENTS-1:0] == $past(link.raw))
    else $error("raw status word stale");

  // Pending word never shows a bit whose global mask was off
  a_pend_masked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in, 3) |-> (pending_out[N_EVENTS-1:0] & ~$past(global_mask_in, 2)) == '0)
    else $error("pending shows masked event");

  // Padding above the events reads as zero
  a_pad_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    raw_status_out[FW-1:N_EVENTS] == '0 && pending_out[FW-1:N_EVENTS] == '0)
    else $error("padding bits not zero");

  // Interrupt lines agree with the status word
  a_irq_route: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_out == out_status_out[event_router_pkg::N_IRQ-1:0])
    else $error("irq lines disagree with status");

  // Wake line agrees with the status word
  a_wake_route: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wake_out == out_status_out[event_router_pkg::WAKE_IDX])
    else $error("wake line disagrees with status");

  // Status bit set exactly when that block had any product
  a_stat_or: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> out_status_out[0] == $past(|product[N_EVENTS-1:0]))
    else $error("status bit not OR of products");

  // Output pending word of the last block follows its products
  a_opend_map: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> out_pending_out[(N_OUTPUTS-1)*FW +: N_EVENTS] ==
      $past(product[(N_OUTPUTS-1)*N_EVENTS +: N_EVENTS]))
    else $error("last block pending word stale");

  // Steady high level in high mode shows on wake after seven sampled edges
  a_level_wake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (event_in[0] && sense_mode_in[1:0] == 2'h0 && global_mask_in[0] &&
     out_mask_in[event_router_pkg::WAKE_IDX*N_EVENTS])[*7] |-> wake_out)
    else $error("high level did not wake");
endmodule
`default_nettype wire

// ==== sim/irq_wake_model.sv ====
// Stand-in for the interrupt controller inputs and the clock unit wake-up input
`timescale 1ns/1ps
`default_nettype none
module irq_wake_model (
  // Clock and reset
  input  wire logic                                sys_clk_in,
  input  wire logic                                rst_in,
  // Routed router outputs and per-line enables
  input  wire logic [event_router_pkg::N_IRQ-1:0] irq_in,
  input  wire logic                                wake_in,
  input  wire logic [event_router_pkg::N_IRQ-1:0] irq_en_in,
  // Requests seen by the processor and the clock unit
  output logic      [event_router_pkg::N_IRQ-1:0] int_req_out,
  output logic                                     wake_req_out
);
  // Per-line enable; a disabled line is simply ignored, never queued
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      int_req_out <= 4'h0;
    end else begin
      int_req_out <= irq_in & irq_en_in;
    end
  end

  // Wake trigger follows output 4; the clock unit adds no gating here
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wake_req_out <= 1'b0;
    end else begin
      wake_req_out <= wake_in;
    end
  end
endmodule
`default_nettype wire

// ==== sim/event_router_tb.sv ====
// Self-checking bench for the event router and its routed outputs
`timescale 1ns/1ps
`default_nettype none
module event_router_tb;
  localparam int NE = event_router_pkg::N_EVENTS;  // Event count
  // Clock and reset
  logic         sys_clk = 1'b0;
  logic         rst     = 1'b1;
  // Stimulus toward the router
  logic [104:0] ev;
  logic [209:0] sense;
  logic [104:0] gmask;
  logic [524:0] omask;
  logic [104:0] eclr;
  logic [3:0]   irq_en;
  // Observed results
  logic [127:0] raw_st;
  logic [127:0] pend_st;
  logic [639:0] opend;
  logic [4:0]   ostat;
  logic [3:0]   irq;
  logic         wake;
  logic [3:0]   int_req;
  logic         wake_req;
  // Score keeping
  int           error_cnt   = 0;
  int           checks_done = 0;
  logic         idle;

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  event_router dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .event_in(ev), .sense_mode_in(sense),
    .global_mask_in(gmask), .out_mask_in(omask), .edge_clear_in(eclr),
    .raw_status_out(raw_st), .pending_out(pend_st), .out_pending_out(opend),
    .out_status_out(ostat), .irq_out(irq), .wake_out(wake)
  );

  irq_wake_model partner (
    .sys_clk_in(sys_clk), .rst_in(rst), .irq_in(irq), .wake_in(wake),
    .irq_en_in(irq_en), .int_req_out(int_req), .wake_req_out(wake_req)
  );

  // Advance n edges, then step off the edge so drives never race sampling
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Vector compare, four-state exact
  task automatic chk(input logic [639:0] got, input logic [639:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // One-hot helper for expected vectors
  function automatic logic [639:0] bit_at(input int i);
    return 640'h1 << i;
  endfunction

  // Single closing point for the run
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard: counts as a mismatch
  initial begin
    #(25 * 20000);
    error_cnt++;
    give_verdict();
  end

  initial begin
    ev = '0; sense = '0; gmask = '0; omask = '0; eclr = '0; irq_en = 4'h0;
    tick(16);
    chk({ostat, raw_st, pend_st}, '0);
    rst = 1'b0;
    // Latency walk: event 0, high level, routed to output 4 only
    gmask = '1;
    omask[4*NE] = 1'b1;
    ev[0] = 1'b1;
    tick(3);
    chk(raw_st, '0);
    tick(1);
    chk(raw_st, bit_at(0));
    tick(1);
    chk(pend_st, bit_at(0));
    tick(1);
    chk(ostat, 640'h10);
    chk({irq, wake}, 640'h1);
    chk(opend, bit_at(512));
    tick(1);
    chk(wake_req, 640'h1);
    ev[0] = 1'b0;
    omask = '0;
    // Every sensitivity mode on event 33, with the sticky flag and its clear
    for (int m = 0; m < 4; m++) begin
      idle = (m == event_router_pkg::SENSE_LOW) || (m == event_router_pkg::SENSE_FALL);
      sense[66 +: 2] = m[1:0];
      ev[33] = idle;
      tick(8);
      eclr[33] = 1'b1;
      tick(1);
      eclr[33] = 1'b0;
      tick(4);
      chk(raw_st[33], 640'h0);
      ev[33] = ~idle;
      tick(6);
      chk(raw_st[33], 640'h1);
      ev[33] = idle;
      tick(6);
      chk(raw_st[33], 640'(m >= 2));
      eclr[33] = 1'b1;
      tick(1);
      eclr[33] = 1'b0;
      tick(4);
      chk(raw_st[33], 640'h0);
    end
    // Global mask gates raw into pending; output 0 reaches the controller
    sense = '0;
    gmask[33] = 1'b0;
    omask[33] = 1'b1;
    ev[33] = 1'b1;
    tick(8);
    chk({raw_st[33], pend_st[33], ostat}, 640'h40);
    gmask[33] = 1'b1;
    tick(8);
    chk({pend_st[33], ostat, int_req}, 640'h210);
    irq_en = 4'h1;
    tick(2);
    chk(int_req, 640'h1);
    ev[33] = 1'b0;
    omask = '0;
    // Top event through each block in turn
    ev[104] = 1'b1;
    for (int o = 0; o < 5; o++) begin
      omask = '0;
      omask[o*NE+104] = 1'b1;
      tick(7);
      chk(pend_st, bit_at(104));
      chk(ostat, bit_at(o));
      chk({wake, irq}, bit_at(o));
      chk(opend, bit_at(o*128+104));
    end
    // OR of two products in block 2
    omask = '0;
    omask[2*NE] = 1'b1;
    omask[2*NE+104] = 1'b1;
    ev[0] = 1'b1;
    tick(7);
    chk(ostat, 640'h4);
    ev[104] = 1'b0;
    tick(7);
    chk(ostat, 640'h4);
    ev[0] = 1'b0;
    tick(7);
    chk(ostat, 640'h0);
    // All inputs high: full raw width, padding stays zero
    ev = '1;
    tick(7);
    chk(raw_st, 640'({NE{1'b1}}));
    chk(pend_st, 640'({NE{1'b1}}));
    give_verdict();
  end
endmodule
`default_nettype wire
